/* File: mag_control_and_event_source.sv */
// control register three and event-source register of the magnetometer
`timescale 1ns/1ps
`default_nettype none
module mag_control_and_event_source
  import mag_ctrl_pkg::*;
#(
  parameter int width = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // register access
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // magnetic samples, one set per output cycle
  input wire logic [2:0][width-1:0] sample_in,
  input wire logic sample_valid,
  input wire logic data_read,
  // offset registers and calibration
  input wire logic [2:0] offset_wr,
  input wire logic [width-1:0] offset_wdata,
  input wire logic acal_en,
  input wire logic [2:0][width-1:0] max_in,
  input wire logic [2:0][width-1:0] min_in,
  // detector events
  input wire logic [2:0] ths_axis_event,
  input wire logic vecm_detect,
  input wire logic vecm_latch_en,
  // oversample selection
  input wire logic [2:0] odr_index,
  input wire logic [2:0] normal_oversample,
  input wire logic auto_sleep,
  // results
  output logic [2:0][width-1:0] sample_out,
  output logic [2:0][width-1:0] offset_out,
  output logic [2:0][width-1:0] ref_out,
  output logic [2:0] active_oversample,
  output logic [osr_count_w-1:0] oversample_count,
  output logic z_selftest_on,
  output logic xy_selftest_on
);

  // ****************************************
  // state
  // ****************************************
  logic [7:0] ctrl_ff; // control_three_register
  logic [7:0] nxt_ctrl;
  logic ths_flag_ff; // threshold event seen
  logic nxt_ths_flag;
  logic vecm_flag_ff; // vector-magnitude event seen
  logic nxt_vecm_flag;
  logic drdy_flag_ff; // fresh data waiting
  logic nxt_drdy_flag;
  logic [7:0] rdata_ff; // read data appears one cycle after the read and holds until the next read
  logic [7:0] nxt_rdata;
  logic [2:0] os_ff; // oversample code in force
  logic [2:0] nxt_os;
  logic [osr_count_w-1:0] os_count_ff; // looked-up oversample count
  logic [osr_count_w-1:0] nxt_os_count;
  logic st_z_ff; // z self-test drive
  logic nxt_st_z;
  logic st_xy_ff; // x and y self-test drive
  logic nxt_st_xy;

  // ****************************************
  // decode
  // ****************************************
  logic ctrl_hit; // access targets the control register
  logic src_hit; // access targets the event-source register
  logic src_read; // read of the event-source register
  logic [7:0] src_value; // assembled event-source byte
  logic ths_any; // any axis tripped the threshold
  logic [2:0] ref_load; // per-axis reference refresh

  assign ctrl_hit = (reg_addr == ctrl_three_addr);
  assign src_hit = (reg_addr == event_src_addr);
  assign src_read = reg_rd && src_hit;
  assign ths_any = |ths_axis_event;

  // event-source byte, spare bits tied low
  always_comb begin
    src_value = event_src_reset;
    src_value[ths_flag_bit] = ths_flag_ff;
    src_value[vecm_flag_bit] = vecm_flag_ff;
    src_value[drdy_flag_bit] = drdy_flag_ff;
  end

  // ****************************************
  // control register and read path
  // ****************************************
  // one write port; reads of unmapped addresses return zero
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_rdata = rdata_ff;
    if (reg_wr && ctrl_hit) begin
      nxt_ctrl = reg_wdata;
    end
    if (reg_rd) begin
      if (ctrl_hit) begin
        nxt_rdata = ctrl_ff;
      end else if (src_hit) begin
        nxt_rdata = src_value;
      end else begin
        nxt_rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff <= ctrl_three_reset;
      rdata_ff <= 8'h00;
    end else begin
      ctrl_ff <= nxt_ctrl;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ****************************************
  // event flags
  // ****************************************
  // a new event in the clearing cycle wins, so no event is lost to a read
  always_comb begin
    nxt_ths_flag = ths_flag_ff;
    nxt_vecm_flag = vecm_flag_ff;
    nxt_drdy_flag = drdy_flag_ff;
    // threshold: sticky until the source register is read
    if (ths_any) begin
      nxt_ths_flag = 1'b1;
    end else if (src_read) begin
      nxt_ths_flag = 1'b0;
    end
    // vector magnitude: sticky when latched, real time otherwise
    if (vecm_latch_en) begin
      if (vecm_detect) begin
        nxt_vecm_flag = 1'b1;
      end else if (src_read) begin
        nxt_vecm_flag = 1'b0;
      end
    end else begin
      nxt_vecm_flag = vecm_detect;
    end
    // new data: set per sample set, cleared when output data is read
    if (sample_valid) begin
      nxt_drdy_flag = 1'b1;
    end else if (data_read) begin
      nxt_drdy_flag = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ths_flag_ff <= 1'b0;
      vecm_flag_ff <= 1'b0;
      drdy_flag_ff <= 1'b0;
    end else begin
      ths_flag_ff <= nxt_ths_flag;
      vecm_flag_ff <= nxt_vecm_flag;
      drdy_flag_ff <= nxt_drdy_flag;
    end
  end

  // ****************************************
  // oversample and self-test
  // ****************************************
  // one cycle behind the control register, two after the control write; the sensor reacts far slower
  always_comb begin
    if (auto_sleep) begin
      nxt_os = ctrl_ff[sleep_os_msb:sleep_os_lsb];
    end else begin
      nxt_os = normal_oversample;
    end
    nxt_os_count = osr_table[odr_index][nxt_os];
    nxt_st_z = ctrl_ff[z_selftest_bit];
    nxt_st_xy = |ctrl_ff[xy_selftest_msb:xy_selftest_lsb];
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      os_ff <= 3'h0;
      os_count_ff <= osr_count_w'(0);
      st_z_ff <= 1'b0;
      st_xy_ff <= 1'b0;
    end else begin
      os_ff <= nxt_os;
      os_count_ff <= nxt_os_count;
      st_z_ff <= nxt_st_z;
      st_xy_ff <= nxt_st_xy;
    end
  end

  assign active_oversample = os_ff;
  assign oversample_count = os_count_ff;
  assign z_selftest_on = st_z_ff;
  assign xy_selftest_on = st_xy_ff;

  // ****************************************
  // per-axis sample paths
  // ****************************************
  // all axes refresh together, or only the tripping ones
  always_comb begin
    if (ctrl_ff[ths_update_bit]) begin
      ref_load = ths_axis_event;
    end else begin
      ref_load = {3{ths_any}};
    end
  end

  for (genvar a = 0; a < 3; a++) begin : g_axis
    mag_axis_path #(
      .width(width)
    ) u_axis (
      .clock(clock),
      .rst_b(rst_b),
      .sample_in(sample_in[a]),
      .sample_valid(sample_valid),
      .raw_mode(ctrl_ff[raw_mode_bit]),
      .offset_wr(offset_wr[a]),
      .offset_wdata(offset_wdata),
      .acal_en(acal_en),
      .max_in(max_in[a]),
      .min_in(min_in[a]),
      .ref_load(ref_load[a]),
      .sample_out(sample_out[a]),
      .offset_out(offset_out[a]),
      .ref_out(ref_out[a])
    );
  end

  // ****************************************
  // checks
  // ****************************************
  sleep_os_select_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    auto_sleep |=> os_ff == $past(ctrl_ff[sleep_os_msb:sleep_os_lsb]))
    else $error("sleep oversample not used");

  ref_all_axes_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    !ctrl_ff[ths_update_bit] && ths_any |-> ref_load == 3'h7)
    else $error("not all references refreshed");

  ref_one_axis_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    ctrl_ff[ths_update_bit] |-> ref_load == ths_axis_event)
    else $error("wrong axis reference refreshed");

  selftest_follow_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    reg_wr && ctrl_hit ##1 1'b1 |=> z_selftest_on == $past(reg_wdata[z_selftest_bit], 2))
    else $error("z self-test does not follow write");

  xy_selftest_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    reg_wr && ctrl_hit && reg_wdata[1:0] == 2'b00 ##2 1'b1 |-> !xy_selftest_on)
    else $error("xy self-test on with zero field");

  rate_800_count_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    odr_index == 3'h7 |=> oversample_count == osr_count_w'(2))
    else $error("800 Hz count not two");

  ths_flag_set_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    ths_any |=> ths_flag_ff ##1 (ths_flag_ff || $past(src_read)))
    else $error("threshold flag lost");

  vecm_hold_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    vecm_latch_en && vecm_flag_ff && !src_read |=> vecm_flag_ff)
    else $error("latched vector flag dropped unread");

  vecm_live_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    !vecm_latch_en |=> vecm_flag_ff == $past(vecm_detect))
    else $error("vector flag not real time");

  drdy_set_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    sample_valid ##1 reg_rd && src_hit |=> reg_rdata[drdy_flag_bit])
    else $error("new-data flag missing");

  spare_zero_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    $past(src_read) |-> reg_rdata[7:3] == 5'h00)
    else $error("spare source bits not zero");

endmodule : mag_control_and_event_source
`default_nettype wire

/* File: mag_ctrl_pkg.sv */
// constants shared by the magnetometer control and event-source logic
package mag_ctrl_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ctrl_three_addr = 8'h5D; // control_three_register
  localparam logic [7:0] event_src_addr = 8'h5E; // magnetometer_event_source
  localparam logic [7:0] ctrl_three_reset = 8'h00;
  localparam logic [7:0] event_src_reset = 8'h00;

  // ****************************************
  // control_three_register fields
  // ****************************************
  localparam int raw_mode_bit = 7; // 1: offsets not applied
  localparam int sleep_os_lsb = 4; // sleep_oversample_select[2:0]
  localparam int sleep_os_msb = 6;
  localparam int ths_update_bit = 3; // 1: only triggering axis reference
  localparam int z_selftest_bit = 2; // z_axis_selftest_enable
  localparam int xy_selftest_lsb = 0; // xy_axes_selftest_enable[1:0]
  localparam int xy_selftest_msb = 1;

  // ****************************************
  // magnetometer_event_source fields
  // ****************************************
  localparam int ths_flag_bit = 2;
  localparam int vecm_flag_bit = 1;
  localparam int drdy_flag_bit = 0;

  // ****************************************
  // oversample count versus output rate
  // ****************************************
  localparam int osr_count_w = 11; // up to 1024
  // row: output rate index 0..7 (1.56 Hz .. 800 Hz), column: oversample code 0..7
  localparam logic [10:0] osr_table [8][8] = '{
    '{11'h010, 11'h010, 11'h020, 11'h040, 11'h080, 11'h100, 11'h200, 11'h400},
    '{11'h004, 11'h004, 11'h008, 11'h010, 11'h020, 11'h040, 11'h080, 11'h100},
    '{11'h002, 11'h002, 11'h004, 11'h008, 11'h010, 11'h020, 11'h040, 11'h080},
    '{11'h002, 11'h002, 11'h002, 11'h002, 11'h004, 11'h008, 11'h010, 11'h020},
    '{11'h002, 11'h002, 11'h002, 11'h002, 11'h002, 11'h004, 11'h008, 11'h010},
    '{11'h002, 11'h002, 11'h002, 11'h002, 11'h002, 11'h002, 11'h004, 11'h008},
    '{11'h002, 11'h002, 11'h002, 11'h002, 11'h002, 11'h002, 11'h002, 11'h004},
    '{11'h002, 11'h002, 11'h002, 11'h002, 11'h002, 11'h002, 11'h002, 11'h002}
  };

endpackage : mag_ctrl_pkg

/* File: mag_axis_path.sv */
// one magnetic axis: offset store, auto-calibration, offset apply, reference
`timescale 1ns/1ps
`default_nettype none
module mag_axis_path #(
  parameter int width = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // sample stream
  input wire logic [width-1:0] sample_in,
  input wire logic sample_valid,
  input wire logic raw_mode,
  // offset register access
  input wire logic offset_wr,
  input wire logic [width-1:0] offset_wdata,
  // auto-calibration
  input wire logic acal_en,
  input wire logic [width-1:0] max_in,
  input wire logic [width-1:0] min_in,
  // threshold reference refresh
  input wire logic ref_load,
  // results
  output logic [width-1:0] sample_out,
  output logic [width-1:0] offset_out,
  output logic [width-1:0] ref_out
);

  logic [width-1:0] offset_ff; // stored hard-iron offset
  logic [width-1:0] nxt_offset;
  logic [width-1:0] sample_ff; // output sample
  logic [width-1:0] nxt_sample;
  logic [width-1:0] ref_ff; // threshold reference
  logic [width-1:0] nxt_ref;
  logic signed [width:0] mid_sum; // one bit wider so max+min never wraps

  // ****************************************
  // next values
  // ****************************************
  always_comb begin
    mid_sum = $signed({max_in[width-1], max_in}) + $signed({min_in[width-1], min_in});
    nxt_offset = offset_ff;
    nxt_sample = sample_ff;
    nxt_ref = ref_ff;
    // a software write wins over calibration in the same cycle
    if (offset_wr) begin
      nxt_offset = offset_wdata;
    end else if (acal_en && sample_valid) begin
      nxt_offset = width'(mid_sum >>> 1);
    end
    if (sample_valid) begin
      if (raw_mode) begin
        nxt_sample = sample_in;
      end else begin
        nxt_sample = sample_in - offset_ff;
      end
    end
    // reference takes the current output sample, compensated or raw as raw_mode selects
    if (ref_load) begin
      nxt_ref = sample_ff;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      offset_ff <= '0;
      sample_ff <= '0;
      ref_ff <= '0;
    end else begin
      offset_ff <= nxt_offset;
      sample_ff <= nxt_sample;
      ref_ff <= nxt_ref;
    end
  end

  assign sample_out = sample_ff;
  assign offset_out = offset_ff;
  assign ref_out = ref_ff;

  // ****************************************
  // checks
  // ****************************************
  raw_passthrough_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    sample_valid && raw_mode |=> sample_ff == $past(sample_in))
    else $error("raw sample altered");

  offset_applied_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    sample_valid && !raw_mode |=> sample_ff == $past(sample_in) - $past(offset_ff))
    else $error("offset not subtracted");

endmodule : mag_axis_path
`default_nettype wire

/* File: mag_control_and_event_source_tb.sv */
// self-checking bench for control register three and the event-source register
`timescale 1ns/1ps
`default_nettype none
module mag_control_and_event_source_tb import mag_ctrl_pkg::*;;
  // ****************************************
  // signals
  // ****************************************
  logic clock; // 25 MHz
  logic rst_b; // active low
  logic [7:0] reg_addr, reg_wdata, reg_rdata; // register access
  logic reg_wr, reg_rd;
  logic [2:0][15:0] sample_in, max_in, min_in; // per-axis inputs
  logic [2:0][15:0] sample_out, offset_out, ref_out; // per-axis results
  logic sample_valid, data_read, acal_en, vecm_detect, vecm_latch_en, auto_sleep;
  logic [2:0] offset_wr, ths_axis_event, odr_index, normal_oversample, active_oversample;
  logic [15:0] offset_wdata;
  logic [osr_count_w-1:0] oversample_count;
  logic z_selftest_on, xy_selftest_on;
  int err_total; // mismatches
  int checks; // comparisons made
  int cycles; // timeout counter

  mag_control_and_event_source #(.width(16)) uut (.clock(clock), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sample_in(sample_in), .sample_valid(sample_valid),
    .data_read(data_read), .offset_wr(offset_wr), .offset_wdata(offset_wdata),
    .acal_en(acal_en), .max_in(max_in), .min_in(min_in), .ths_axis_event(ths_axis_event),
    .vecm_detect(vecm_detect), .vecm_latch_en(vecm_latch_en), .odr_index(odr_index),
    .normal_oversample(normal_oversample), .auto_sleep(auto_sleep),
    .sample_out(sample_out), .offset_out(offset_out), .ref_out(ref_out),
    .active_oversample(active_oversample), .oversample_count(oversample_count),
    .z_selftest_on(z_selftest_on), .xy_selftest_on(xy_selftest_on));

  // ****************************************
  // clock and timeout
  // ****************************************
  always #20 clock = ~clock;

  // a hang would otherwise never reach the verdict
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total = err_total + 1;
      stop_test();
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  // compare one result, widened to 16 bits
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one-cycle write strobe, one idle cycle so strobes never merge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    @(negedge clock);
  endtask : wr

  // read strobe, data looked at once it is held
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    @(negedge clock);
    chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask : rd

  // one sample set, index 0 is x
  task automatic smp(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
    sample_in = {z, y, x};
    sample_valid = 1'b1;
    @(negedge clock);
    sample_valid = 1'b0;
    @(negedge clock);
  endtask : smp

  // one-cycle pulse on a threshold trigger mask
  task automatic ths(input logic [2:0] m);
    ths_axis_event = m;
    @(negedge clock);
    ths_axis_event = 3'h0;
    @(negedge clock);
  endtask : ths

  // expected oversample count, worked out as a power of two per rate row
  function automatic logic [15:0] osr_exp(input int r, input int c);
    int k [8] = '{3, 1, 0, -2, -3, -4, -5, -8};
    int e;
    e = ((c < 1) ? 1 : c) + k[r];
    if (e < 1) begin
      e = 1;
    end
    return 16'(1 << e);
  endfunction : osr_exp

  // verdict, reached from the main sequence and the timeout alike
  task automatic stop_test();
    $display("errors %0d comparisons %0d", err_total, checks);
    if (err_total == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    clock = 1'b0;
    rst_b = 1'b0;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {sample_in, max_in, min_in, sample_valid, data_read, acal_en} = '0;
    {offset_wr, offset_wdata, ths_axis_event, vecm_detect, vecm_latch_en} = '0;
    {odr_index, normal_oversample, auto_sleep} = '0;
    err_total = 0;
    checks = 0;
    cycles = 0;
    repeat (20) @(negedge clock);
    rst_b = 1'b1;
    @(negedge clock);
    // reset contents, read-only and unmapped places
    rd(ctrl_three_addr, 8'h00);
    rd(event_src_addr, 8'h00);
    wr(event_src_addr, 8'hFF);
    wr(8'h5F, 8'hAA);
    rd(event_src_addr, 8'h00);
    rd(8'h5F, 8'h00);
    wr(ctrl_three_addr, 8'hA5);
    rd(ctrl_three_addr, 8'hA5);
    // self-test enables for every z and xy combination
    for (int v = 0; v < 8; v++) begin
      wr(ctrl_three_addr, 8'(v));
      @(negedge clock);
      chk({15'h0, z_selftest_on}, {15'h0, v[2]});
      chk({15'h0, xy_selftest_on}, {15'h0, |v[1:0]});
    end
    // sleep code against every rate row
    auto_sleep = 1'b1;
    for (int c = 0; c < 8; c++) begin
      wr(ctrl_three_addr, 8'(c << 4));
      for (int r = 0; r < 8; r++) begin
        odr_index = 3'(r);
        repeat (3) @(negedge clock);
        chk({13'h0, active_oversample}, 16'(c));
        chk({5'h0, oversample_count}, osr_exp(r, c));
      end
    end
    // outside auto-sleep the normal code is in force
    auto_sleep = 1'b0;
    normal_oversample = 3'h6;
    odr_index = 3'h0;
    repeat (3) @(negedge clock);
    chk({13'h0, active_oversample}, 16'h0006);
    chk({5'h0, oversample_count}, osr_exp(0, 6));
    // offsets applied, with wrap at the bottom of the range
    wr(ctrl_three_addr, 8'h00);
    offset_wdata = 16'h0010;
    offset_wr = 3'h7;
    @(negedge clock);
    offset_wr = 3'h0;
    @(negedge clock);
    smp(16'h0100, 16'h0005, 16'h8000);
    chk(sample_out[0], 16'h00F0);
    chk(sample_out[1], 16'hFFF5);
    chk(sample_out[2], 16'h7FF0);
    rd(event_src_addr, 8'h01);
    data_read = 1'b1;
    @(negedge clock);
    data_read = 1'b0;
    @(negedge clock);
    rd(event_src_addr, 8'h00);
    // source read in the very next cycle after a sample set sees the flag
    sample_valid = 1'b1;
    @(negedge clock);
    sample_valid = 1'b0;
    rd(event_src_addr, 8'h01);
    // raw mode passes samples untouched
    wr(ctrl_three_addr, 8'h80);
    smp(16'h0100, 16'h0005, 16'h8000);
    chk(sample_out[0], 16'h0100);
    chk(sample_out[2], 16'h8000);
    // one trigger refreshes all references, flag sticks until read
    ths(3'h4);
    chk(ref_out[0], 16'h0100);
    chk(ref_out[1], 16'h0005);
    chk(ref_out[2], 16'h8000);
    rd(event_src_addr, 8'h05);
    rd(event_src_addr, 8'h01);
    // per-axis refresh leaves the other references alone
    wr(ctrl_three_addr, 8'h88);
    smp(16'h1111, 16'h2222, 16'h3333);
    ths(3'h2);
    chk(ref_out[0], 16'h0100);
    chk(ref_out[1], 16'h2222);
    chk(ref_out[2], 16'h8000);
    // latched vector flag outlives the detector pulse
    vecm_latch_en = 1'b1;
    vecm_detect = 1'b1;
    @(negedge clock);
    vecm_detect = 1'b0;
    repeat (2) @(negedge clock);
    // threshold flag from the per-axis trigger is still pending here
    rd(event_src_addr, 8'h07);
    rd(event_src_addr, 8'h01);
    // unlatched flag follows the detector
    vecm_latch_en = 1'b0;
    vecm_detect = 1'b1;
    repeat (2) @(negedge clock);
    rd(event_src_addr, 8'h03);
    vecm_detect = 1'b0;
    repeat (2) @(negedge clock);
    rd(event_src_addr, 8'h01);
    // auto-calibration mid-point, full 17-bit sum on z
    acal_en = 1'b1;
    max_in = {16'h7FFF, 16'h0040, 16'h0100};
    min_in = {16'h7FFF, 16'h0020, 16'hFF00};
    smp(16'h0001, 16'h0002, 16'h0003);
    acal_en = 1'b0;
    chk(offset_out[0], 16'h0000);
    chk(offset_out[1], 16'h0030);
    chk(offset_out[2], 16'h7FFF);
    // second reset in mid-run clears both registers
    rst_b = 1'b0;
    @(negedge clock);
    rst_b = 1'b1;
    @(negedge clock);
    rd(ctrl_three_addr, 8'h00);
    rd(event_src_addr, 8'h00);
    stop_test();
  end
endmodule : mag_control_and_event_source_tb
`default_nettype wire
